// File: pswc_pkg.sv
// package: register map, field layout and timing for the power state wake controller
package pswc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_OFS  = 8'h00;  // power_control_reg
  localparam logic [7:0] WAKE_TEST_OFS = 8'h04;  // wake test register
  localparam logic [7:0] IRQ_STS_OFS   = 8'h08;  // irq_status_reg
  localparam logic [7:0] IRQ_EN_OFS    = 8'h0c;  // interrupt enables
  localparam logic [7:0] PHY_CTRL_OFS  = 8'h10;  // phy power control

  // ----------------------------------------------------------------
  // power_control_reg fields
  // ----------------------------------------------------------------
  localparam int READY_BIT     = 0;
  localparam int PIN_EN_BIT    = 1;
  localparam int PULSE_SEL_BIT = 3;
  localparam int SRC_LO        = 4;
  localparam int LAN_EN_BIT    = 8;
  localparam int ENERGY_WAKE_ENABLE_BIT     = 9;
  localparam int PSTATE_LO     = 12;

  // irq_status_reg / irq enable fields
  localparam int WAKE_IRQ_BIT   = 0;
  localparam int ENERGY_IRQ_BIT = 1;

  // phy control fields
  localparam int GEN_PD_BIT    = 0;
  localparam int ED_SLEEP_BIT  = 1;
  localparam int ED_FLAG_BIT   = 2;
  localparam int ENERGY_IN_BIT = 3;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    normal_state      = 2'b00,
    light_sleep_state = 2'b01,
    deep_sleep_state  = 2'b10,
    reserved_state    = 2'b11
  } pswc_state_t;

  localparam logic [1:0]  SRC_NONE   = 2'b00;
  localparam logic [1:0]  SRC_ENERGY = 2'b01;
  localparam logic [1:0]  SRC_FRAME  = 2'b10;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLV   = 2'b10;
  localparam logic [31:0] WAKE_TEST_VAL = 32'h8765_4321; // arbitrary read pattern

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned RESUME_MAX_US = 2000;        // ready within 2 ms
  localparam int unsigned PIN_PULSE_MS  = 50;          // pulsed wake pin width
  localparam int unsigned RESUME_CYC_DF = RESUME_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PULSE_CYC_DF  = PIN_PULSE_MS * (CLK_HZ / 1000);
  localparam int          CNT_W         = 21;

endpackage : pswc_pkg

// File: pswc_power_ctrl.sv
// module: power state and wake event controller with axi4-lite register slave
//
// Functional notes
// - write 01 enters light sleep, clears ready
// - write 10 enters deep sleep, clears ready
// - wake test write returns to normal state
// - writes ignored until first read after wake
// - light sleep frame detect sets source 10
// - deep sleep energy sets source 01
// - wake irq status independent of pin enable
// - wake status sticky until source removed, w1c
// - pulse select: 50ms pulse, else static
// - pin drops on source, enable or pin-enable clear
// - light sleep keeps phy, pm clocks only
// - deep sleep stops mac, bus clocks, phy sleeps
// - registers preserved across sleep states
// - general power-down holds phy; clear resets it
// - energy sleep powers phy down without energy
// - energy event raises host interrupt when enabled
// - ready set within 2ms after wake write
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module pswc_power_ctrl
  import pswc_pkg::*;
#(
  parameter int unsigned RESUME_CYC = RESUME_CYC_DF,
  parameter int unsigned PULSE_CYC  = PULSE_CYC_DF
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // wake sources
  input  wire logic        wake_frame_detect,
  input  wire logic        line_energy_present,
  // wake and interrupt outputs
  output logic             wake_pin,
  output logic             host_irq,
  // clock gating and phy power
  output logic             phy_clk_en,
  output logic             pm_clk_en,
  output logic             mac_clk_en,
  output logic             host_clk_en,
  output logic             phy_power_down,
  output logic             phy_reset,
  output logic             phy_energy_down
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic lane_on(input logic [3:0] strb, input int bitpos);
    lane_on = strb[bitpos / 8];
  endfunction : lane_on

  function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] c);
    cnt_dec = (c == '0) ? c : c - CNT_W'(1);
  endfunction : cnt_dec

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pswc_state_t      pstate_q;
  logic             ready_q;
  logic             first_rd_q;
  logic             pin_en_q;
  logic             pulse_sel_q;
  logic             lan_en_q;
  logic             energy_wake_enable_q;
  logic [1:0]       src_q;
  logic             wake_sts_q;
  logic [1:0]       irq_en_q;
  logic             gen_pd_q;
  logic             ed_sleep_q;
  logic             ed_flag_q;
  logic             energy_q;
  logic             pme_int_q;
  logic [CNT_W-1:0] pulse_cnt_q;
  logic [CNT_W-1:0] resume_cnt_q;
  logic             aw_have_q;
  logic             w_have_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;

  logic asleep;
  logic wr_fire;
  logic wr_hit;
  logic wake_wr;
  logic wr_ok;
  logic rd_fire;
  logic pme_int;
  logic [1:0] src_clr;

  assign asleep  = (pstate_q != normal_state);
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit  = (awaddr_q == PWR_CTRL_OFS) || (awaddr_q == WAKE_TEST_OFS) || (awaddr_q == IRQ_STS_OFS)
                   || (awaddr_q == IRQ_EN_OFS) || (awaddr_q == PHY_CTRL_OFS);
  assign wake_wr = wr_fire && asleep && (awaddr_q == WAKE_TEST_OFS);
  assign wr_ok   = wr_fire && ready_q && first_rd_q && !asleep;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // internal wake interrupt: source paired with its enable
  assign pme_int = ((src_q == SRC_FRAME) && lan_en_q) || ((src_q == SRC_ENERGY) && energy_wake_enable_q);

  // w1c mask for the wake source field
  assign src_clr = (wr_ok && (awaddr_q == PWR_CTRL_OFS) && lane_on(wstrb_q, SRC_LO))
                   ? wdata_q[SRC_LO +: 2] : 2'b00;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && !aw_have_q) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && !w_have_q) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == PWR_CTRL_OFS) begin
        s_axi_rdata[READY_BIT]         <= ready_q;
        s_axi_rdata[PIN_EN_BIT]        <= pin_en_q;
        s_axi_rdata[PULSE_SEL_BIT]     <= pulse_sel_q;
        s_axi_rdata[SRC_LO +: 2]       <= src_q;
        s_axi_rdata[LAN_EN_BIT]        <= lan_en_q;
        s_axi_rdata[ENERGY_WAKE_ENABLE_BIT]         <= energy_wake_enable_q;
        s_axi_rdata[PSTATE_LO +: 2]    <= pstate_q;
      end else if (!ready_q) begin
        s_axi_rresp <= RESP_SLV;
      end else if (s_axi_araddr == WAKE_TEST_OFS) begin
        s_axi_rdata <= WAKE_TEST_VAL;
      end else if (s_axi_araddr == IRQ_STS_OFS) begin
        s_axi_rdata[WAKE_IRQ_BIT]   <= wake_sts_q;
        s_axi_rdata[ENERGY_IRQ_BIT] <= ed_flag_q;
      end else if (s_axi_araddr == IRQ_EN_OFS) begin
        s_axi_rdata[1:0] <= irq_en_q;
      end else if (s_axi_araddr == PHY_CTRL_OFS) begin
        s_axi_rdata[GEN_PD_BIT]    <= gen_pd_q;
        s_axi_rdata[ED_SLEEP_BIT]  <= ed_sleep_q;
        s_axi_rdata[ED_FLAG_BIT]   <= ed_flag_q;
        s_axi_rdata[ENERGY_IN_BIT] <= line_energy_present;
      end else begin
        s_axi_rresp <= RESP_SLV;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power state, ready and first-read gate
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pstate_q <= normal_state;
    end else if (wake_wr) begin
      pstate_q <= normal_state;
    end else if (wr_ok && (awaddr_q == PWR_CTRL_OFS) && lane_on(wstrb_q, PSTATE_LO)) begin
      if (wdata_q[PSTATE_LO +: 2] == light_sleep_state) begin
        pstate_q <= light_sleep_state;
      end else if (wdata_q[PSTATE_LO +: 2] == deep_sleep_state) begin
        pstate_q <= deep_sleep_state;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_q      <= 1'b1;
      resume_cnt_q <= '0;
    end else if (wake_wr) begin
      resume_cnt_q <= CNT_W'(RESUME_CYC);
    end else if (resume_cnt_q != '0) begin
      resume_cnt_q <= cnt_dec(resume_cnt_q);
      ready_q      <= (resume_cnt_q == CNT_W'(1));
    end else if (asleep) begin
      ready_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_rd_q <= 1'b0;
    end else if (wake_wr) begin
      first_rd_q <= 1'b0;
    end else if (rd_fire && ready_q) begin
      first_rd_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration bits, kept across sleep
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_en_q    <= 1'b0;
      pulse_sel_q <= 1'b0;
      lan_en_q    <= 1'b0;
      energy_wake_enable_q     <= 1'b0;
    end else if (wr_ok && (awaddr_q == PWR_CTRL_OFS)) begin
      if (lane_on(wstrb_q, PIN_EN_BIT)) begin
        pin_en_q    <= wdata_q[PIN_EN_BIT];
        pulse_sel_q <= wdata_q[PULSE_SEL_BIT];
      end
      if (lane_on(wstrb_q, LAN_EN_BIT)) begin
        lan_en_q <= wdata_q[LAN_EN_BIT];
        energy_wake_enable_q  <= wdata_q[ENERGY_WAKE_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q   <= 2'b00;
      gen_pd_q   <= 1'b0;
      ed_sleep_q <= 1'b0;
    end else if (wr_ok && (awaddr_q == IRQ_EN_OFS) && lane_on(wstrb_q, WAKE_IRQ_BIT)) begin
      irq_en_q <= wdata_q[1:0];
    end else if (wr_ok && (awaddr_q == PHY_CTRL_OFS) && lane_on(wstrb_q, GEN_PD_BIT)) begin
      gen_pd_q   <= wdata_q[GEN_PD_BIT];
      ed_sleep_q <= wdata_q[ED_SLEEP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // wake source detection and status
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= SRC_NONE;
    end else if ((pstate_q == light_sleep_state) && wake_frame_detect) begin
      src_q <= SRC_FRAME;
    end else if ((pstate_q == deep_sleep_state) && line_energy_present) begin
      src_q <= SRC_ENERGY;
    end else begin
      src_q <= src_q & ~src_clr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_sts_q <= 1'b0;
    end else if (pme_int) begin
      wake_sts_q <= 1'b1;
    end else if (wr_ok && (awaddr_q == IRQ_STS_OFS) && lane_on(wstrb_q, WAKE_IRQ_BIT)
                 && wdata_q[WAKE_IRQ_BIT]) begin
      wake_sts_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wake pin, static or pulsed
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pme_int_q   <= 1'b0;
      pulse_cnt_q <= '0;
    end else begin
      pme_int_q <= pme_int;
      if (pme_int && !pme_int_q) begin
        pulse_cnt_q <= CNT_W'(PULSE_CYC);
      end else begin
        pulse_cnt_q <= cnt_dec(pulse_cnt_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_pin <= 1'b0;
    end else begin
      wake_pin <= pin_en_q && pme_int && (!pulse_sel_q || (pulse_cnt_q != '0));
    end
  end

  // ----------------------------------------------------------------
  // host interrupt and energy flag
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      energy_q  <= 1'b0;
      ed_flag_q <= 1'b0;
    end else begin
      energy_q <= line_energy_present;
      if (ed_sleep_q && line_energy_present && !energy_q) begin
        ed_flag_q <= 1'b1;
      end else if (wr_ok && (awaddr_q == IRQ_STS_OFS) && lane_on(wstrb_q, ENERGY_IRQ_BIT)
                   && wdata_q[ENERGY_IRQ_BIT]) begin
        ed_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= (wake_sts_q && irq_en_q[WAKE_IRQ_BIT])
                  || (ed_flag_q && irq_en_q[ENERGY_IRQ_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // clock gating and phy power
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_clk_en      <= 1'b1;
      pm_clk_en       <= 1'b1;
      mac_clk_en      <= 1'b1;
      host_clk_en     <= 1'b1;
      phy_power_down  <= 1'b0;
      phy_reset       <= 1'b0;
      phy_energy_down <= 1'b0;
    end else begin
      phy_clk_en      <= (pstate_q != deep_sleep_state);
      pm_clk_en       <= (pstate_q != deep_sleep_state);
      mac_clk_en      <= !asleep;
      host_clk_en     <= !asleep;
      phy_power_down  <= gen_pd_q;
      phy_reset       <= phy_power_down && !gen_pd_q;
      phy_energy_down <= (ed_sleep_q || (pstate_q == deep_sleep_state)) && !line_energy_present;
    end
  end

endmodule : pswc_power_ctrl

`default_nettype wire

// File: pswc_power_ctrl_asserts.sv
// checker: port-level assertions for the power state wake controller
`timescale 1ns/100ps
`default_nettype none

module pswc_power_ctrl_asserts
  import pswc_pkg::*;
#(
  parameter int unsigned RESUME_CYC = RESUME_CYC_DF,
  parameter int unsigned PULSE_CYC  = PULSE_CYC_DF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read handshake
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // line and power outputs
  input wire logic line_energy_present,
  input wire logic wake_pin,
  input wire logic phy_clk_en,
  input wire logic pm_clk_en,
  input wire logic mac_clk_en,
  input wire logic host_clk_en,
  input wire logic phy_power_down,
  input wire logic phy_reset,
  input wire logic phy_energy_down
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_light_pm_clock: assert property (phy_clk_en && !mac_clk_en |-> pm_clk_en)
    else $error("pm clock stopped while phy clock runs");
  a_deep_all_off: assert property (!phy_clk_en |-> !pm_clk_en && !mac_clk_en && !host_clk_en)
    else $error("a clock runs while phy clock is stopped");
  a_mac_host_pair: assert property (mac_clk_en == host_clk_en)
    else $error("mac and host clock enables differ");
  a_deep_phy_sleep: assert property (!$past(phy_clk_en, 2) && !phy_clk_en && !$past(line_energy_present)
    |-> phy_energy_down)
    else $error("phy not in energy sleep during deep sleep");
  a_energy_wakes_phy: assert property (phy_energy_down |-> !$past(line_energy_present))
    else $error("phy held down while line energy present");
  a_reset_one_cycle: assert property (phy_reset |=> !phy_reset)
    else $error("phy reset pulse longer than one cycle");
  a_powerup_resets: assert property ($fell(phy_power_down) |-> ##[0:2] phy_reset)
    else $error("no phy reset after power-down cleared");
  a_down_no_reset: assert property (phy_power_down |-> !phy_reset)
    else $error("phy reset while powered down");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");

  c_deep: cover property (!phy_clk_en);
  c_pin: cover property ($rose(wake_pin));
  c_phy_reset: cover property (phy_reset);

endmodule : pswc_power_ctrl_asserts

bind pswc_power_ctrl pswc_power_ctrl_asserts #(.RESUME_CYC(RESUME_CYC), .PULSE_CYC(PULSE_CYC)) u_asserts (.*);

`default_nettype wire

// File: pswc_line_model.sv
// model: line side of the phy, source of wake frames and line energy
`timescale 1ns/100ps
`default_nettype none

module pswc_line_model (
  // clock
  input  wire logic aclk,
  // line events
  output var logic  wake_frame_detect,
  output var logic  line_energy_present
);
  initial begin
    wake_frame_detect   = 1'h0;
    line_energy_present = 1'h0;
  end

  // one matching frame, one cycle wide
  task automatic send_frame();
    @(posedge aclk);
    wake_frame_detect <= 1'h1;
    @(posedge aclk);
    wake_frame_detect <= 1'h0;
  endtask : send_frame

  // carrier on or off from the next edge
  task automatic set_energy(input logic on);
    @(posedge aclk);
    line_energy_present <= on;
  endtask : set_energy
endmodule : pswc_line_model

`default_nettype wire

// File: pswc_power_ctrl_tb_top.sv
// testbench: power state wake controller scenarios over axi4-lite
`timescale 1ns/100ps
`default_nettype none

module pswc_power_ctrl_tb_top;
  import pswc_pkg::*;
  localparam int unsigned RES_C = 20;
  localparam int unsigned PUL_C = 16;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [1:0]  last_resp = 2'h0;
  logic        wake_frame_detect, line_energy_present, wake_pin, host_irq;
  logic        phy_clk_en, pm_clk_en, mac_clk_en, host_clk_en, phy_power_down, phy_reset, phy_energy_down;
  int          mismatches = 0, checks = 0, cyc = 0, rst_n = 0;

  // ----------------------------------------------------------------
  // clock, instances, monitors
  // ----------------------------------------------------------------
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (phy_reset === 1'h1) rst_n <= rst_n + 1;
  end
  pswc_power_ctrl #(.RESUME_CYC(RES_C), .PULSE_CYC(PUL_C)) dut (.*);
  pswc_line_model u_line (.*);

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ah, dh;
    ah = 0;
    dh = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ah && dh)) begin
      @(posedge aclk);
      if (!ah && s_axi_awready === 1'h1) begin ah = 1; s_axi_awvalid <= 1'h0; end
      if (!dh && s_axi_wready === 1'h1) begin dh = 1; s_axi_wvalid <= 1'h0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    last_resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask : rd

  task automatic wake();
    logic [31:0] d;
    int          t0;
    t0 = cyc;
    wr(WAKE_TEST_OFS, 32'h0000_0000);
    d = 32'h0;
    while (d[0] !== 1'h1 && cyc - t0 < 200) rd(PWR_CTRL_OFS, d);
    chk("resume time", 32'(cyc - t0 <= RES_C + 8), 32'h1);
    chk("state after wake", d[13:12], normal_state);
  endtask : wake

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    logic [31:0] d;
    wr(PWR_CTRL_OFS, 32'h0000_0002);
    rd(PWR_CTRL_OFS, d);
    chk("pin enable before read", d[1], 1'h0);
    chk("wake source idle", d[5:4], SRC_NONE);
    wr(PWR_CTRL_OFS, 32'h0000_0002);
    rd(PWR_CTRL_OFS, d);
    chk("pin enable after read", d[1], 1'h1);
    $display("test boot done");
  endtask : t_boot

  task automatic t_light();
    logic [31:0] d;
    wr(PWR_CTRL_OFS, 32'h0000_1102);
    repeat (3) @(posedge aclk);
    chk("light clocks", {phy_clk_en, pm_clk_en, mac_clk_en, host_clk_en}, 4'hc);
    rd(PWR_CTRL_OFS, d);
    chk("asleep read resp", last_resp, RESP_OKAY);
    chk("ready light", d[0], 1'h0);
    chk("state light", d[13:12], light_sleep_state);
    u_line.send_frame();
    repeat (4) @(posedge aclk);
    chk("static pin", wake_pin, 1'h1);
    rd(PWR_CTRL_OFS, d);
    chk("frame source", d[5:4], SRC_FRAME);
    wake();
    rd(IRQ_STS_OFS, d);
    chk("wake irq status", d[0], 1'h1);
    wr(IRQ_STS_OFS, 32'h1);
    rd(IRQ_STS_OFS, d);
    chk("wake irq sticky", d[0], 1'h1);
    wr(PWR_CTRL_OFS, 32'h0000_0132);
    repeat (3) @(posedge aclk);
    chk("pin drops", wake_pin, 1'h0);
    wr(IRQ_STS_OFS, 32'h1);
    rd(IRQ_STS_OFS, d);
    chk("wake irq cleared", d[0], 1'h0);
    $display("test light sleep done");
  endtask : t_light

  task automatic t_deep();
    logic [31:0] d;
    int          n;
    wr(IRQ_EN_OFS, 32'h2);
    wr(PHY_CTRL_OFS, 32'h2);
    wr(PWR_CTRL_OFS, 32'h0000_220a);
    repeat (3) @(posedge aclk);
    chk("deep clocks", {phy_clk_en, pm_clk_en, mac_clk_en, host_clk_en}, 4'h0);
    chk("phy energy down", phy_energy_down, 1'h1);
    u_line.set_energy(1'h1);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      n += int'(wake_pin === 1'h1);
    end
    chk("pulse width", n, PUL_C);
    chk("phy up on energy", phy_energy_down, 1'h0);
    rd(PWR_CTRL_OFS, d);
    chk("ready deep", d[0], 1'h0);
    chk("energy source", d[5:4], SRC_ENERGY);
    wake();
    chk("energy irq", host_irq, 1'h1);
    wr(PHY_CTRL_OFS, 32'h0);
    rd(PHY_CTRL_OFS, d);
    chk("energy flag", d[2], 1'h1);
    rd(PWR_CTRL_OFS, d);
    chk("settings kept", d & 32'h30a, 32'h20a);
    u_line.set_energy(1'h0);
    wr(PWR_CTRL_OFS, 32'h0000_023a);
    $display("test deep sleep done");
  endtask : t_deep

  task automatic t_phy();
    int r0;
    wr(PHY_CTRL_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("phy power down", phy_power_down, 1'h1);
    r0 = rst_n;
    wr(PHY_CTRL_OFS, 32'h0);
    repeat (4) @(posedge aclk);
    chk("phy reset pulses", rst_n - r0, 1);
    chk("phy powered up", phy_power_down, 1'h0);
    $display("test phy power down done");
  endtask : t_phy

  task automatic t_reset();
    logic [31:0] d;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("clocks after reset", {phy_clk_en, pm_clk_en, mac_clk_en, host_clk_en}, 4'hf);
    chk("irq after reset", host_irq, 1'h0);
    chk("pin after reset", wake_pin, 1'h0);
    wr(PWR_CTRL_OFS, 32'h0000_0002);
    chk("ignored write resp", last_resp, RESP_OKAY);
    rd(PWR_CTRL_OFS, d);
    chk("control after reset", d & 32'h0000_333b, 32'h0000_0001);
    chk("source after reset", d[5:4], SRC_NONE);
    $display("test mid-run reset done");
  endtask : t_reset

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_boot();
    t_light();
    t_deep();
    t_phy();
    t_reset();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    complete_run();
  end
endmodule : pswc_power_ctrl_tb_top

`default_nettype wire
